// ### src/scaler_pkg.sv
// Summary of operation
// - pixels pass vertical stretch, horizontal filter, colour conversion, horizontal stretch.
// - horizontal and vertical stretch factors are programmed independently, any value.
// - vertical stretch blends current line with previous line held in a line store.
// - after vertical blend, luma goes through edge-enhance or smoothing filter as selected.
// - YUV 4:2:2 input pixels become 24-bit RGB pixels.
// - after reset the converter uses YCrCb to gamma-corrected RGB coefficients.
// - each converted component is clamped to the 0..255 output range.
// - a four-bit selector picks one of 16 hue/saturation coefficient sets.
// - red, green and blue each get their own programmable brightness offset.
// - horizontal stretch blends neighbouring RGB pixels with a 2-tap triangle filter.
// - video is clipped to a window given by position, width and height.
// - source fetch uses a programmable start address and line pitch for panning.
// - with keying on, video shows only where the graphics pixel equals the key.
// - with keying off and overlay on, video replaces graphics inside the window.
// - both progressive and interlaced sources can be displayed.
// - interlaced sources show every field in turn, one field per display frame.
// - each field is stretched vertically to full target height by line interpolation.
// - the bottom field starts half a source line lower so both fields align.
// - one field stored per frame, buffers alternate per field, each line's luma is averaged with that of the previous fetched line.
// - interpolation is 2 taps across by 2 lines down, with sharpening.
package scaler_pkg;

  // ==========================================================================
  // register map, byte addresses
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_KEY       = 8'h04;
  localparam logic [7:0] OFF_WIN_POS   = 8'h08;
  localparam logic [7:0] OFF_WIN_SIZE  = 8'h0C;
  localparam logic [7:0] OFF_START     = 8'h10;
  localparam logic [7:0] OFF_PITCH     = 8'h14;
  localparam logic [7:0] OFF_SRC_W     = 8'h18;
  localparam logic [7:0] OFF_STEP      = 8'h1C;
  localparam logic [7:0] OFF_BRIGHT    = 8'h20;
  localparam logic [7:0] OFF_FIELD_OFF = 8'h24;
  localparam logic [7:0] OFF_STATUS    = 8'h28;

  // ==========================================================================
  // control field positions
  localparam int CTRL_OVL_BIT   = 0;
  localparam int CTRL_KEY_BIT   = 1;
  localparam int CTRL_EDGE_BIT  = 2;
  localparam int CTRL_ILACE_BIT = 3;
  localparam int CTRL_TAVG_BIT  = 4;
  localparam int CTRL_CSC_LSB   = 8;

  // ==========================================================================
  // reset values and phase constants (8.8 fixed point)
  localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
  localparam logic [15:0] STEP_RST      = 16'h0100;
  localparam logic [11:0] SRC_W_RST     = 12'h280;
  localparam logic [11:0] WIN_W_RST     = 12'h280;
  localparam logic [11:0] WIN_H_RST     = 12'h1E0;
  localparam logic [15:0] PITCH_RST     = 16'h0500;
  localparam logic [7:0]  PHASE_HALF    = 8'h80;
  localparam logic [9:0]  PRIME_CNT     = 10'h002;

  // ==========================================================================
  // colour conversion, coefficients scaled by 256
  localparam int Y_OFS = 16;
  localparam int C_OFS = 128;
  localparam int K_Y   = 298;
  localparam int K_RV  = 409;
  localparam int K_GU  = 100;
  localparam int K_GV  = 208;
  localparam int K_BU  = 516;
  localparam int ROUND = 128;
  localparam int SAT_TAB [4] = '{256, 192, 320, 128};
  localparam int HUE_TAB [4] = '{0, 16, -16, 32};

  typedef enum {ST_IDLE, ST_FETCH, ST_RUN, ST_DRAIN} line_state_type;

endpackage

// ### src/video_overlay_scaler.sv
`timescale 1ns/1ns
module video_overlay_scaler
  import scaler_pkg::*;
#(
  parameter int MAX_W = 1024                 // line store depth in source pixels
) (
  input  wire logic        clk,              // pixel clock
  input  wire logic        rstn,             // async reset, active low
  input  wire logic [7:0]  reg_addr,         // register byte address
  input  wire logic [31:0] reg_wdata,        // register write data
  input  wire logic        reg_wr,           // write strobe
  input  wire logic        reg_rd,           // read strobe
  output logic      [31:0] reg_rdata,        // read data, cycle after strobe
  output logic             fetch_valid,      // line fetch request
  input  wire logic        fetch_ready,      // memory controller took request
  output logic      [31:0] fetch_addr,       // line start address
  output logic      [11:0] fetch_len,        // pixels to return
  input  wire logic        src_valid,        // source pixel valid
  output logic             src_ready,        // source pixel accepted
  input  wire logic [15:0] src_data,         // {chroma, luma}, Cb on even pixels
  input  wire logic        gfx_valid,        // graphics pixel valid
  output logic             gfx_ready,        // graphics pixel accepted
  input  wire logic        gfx_sof,          // first pixel of a frame
  input  wire logic [11:0] gfx_x,            // graphics column
  input  wire logic [11:0] gfx_y,            // graphics row
  input  wire logic [23:0] gfx_pixel,        // graphics RGB
  output logic             out_valid,        // display pixel valid
  input  wire logic        out_ready,        // display takes pixel
  output logic      [23:0] out_pixel         // composited RGB
);

  localparam int IDX_W = $clog2(MAX_W);

  // ==========================================================================
  // registers
  logic [31:0] ctrl_reg, key_reg, start_reg, field_off_reg, bright_reg;
  logic [11:0] win_x_reg, win_y_reg, win_w_reg, win_h_reg, src_w_reg;
  logic [15:0] pitch_reg, hstep_reg, vstep_reg;
  logic [31:0] rdata_reg;

  line_state_type st_reg;
  logic           line_pend_reg, field_reg, v_store_reg;
  logic [7:0]     vfrac_reg, hfrac_reg;
  logic [11:0]    src_line_reg, src_cnt_reg, out_cnt_reg;
  logic [9:0]     h_need_reg;
  logic           src_ready_reg, c_valid_reg, gfx_ready_reg, out_valid_reg;
  logic [7:0]     y1_reg, y2_reg, cb_reg, cr_reg;
  logic [23:0]    c_rgb_reg, hp0_reg, hp1_reg, out_pixel_reg;
  logic           fetch_valid_reg;
  logic [31:0]    fetch_addr_reg;

  logic [15:0] lb_mem  [MAX_W];              // previous source line
  logic [7:0]  fld_mem [MAX_W];              // blended luma of the previously fetched line

  // ==========================================================================
  // arithmetic helpers
  function automatic logic [7:0] clamp8(input int v);
    if (v < 0) begin
      return 8'h00;
    end else if (v > 255) begin
      return 8'hFF;
    end
    return v[7:0];
  endfunction

  function automatic logic [7:0] lerp8(input logic [7:0] a, input logic [7:0] b,
                                       input logic [7:0] w);
    int d;
    d = int'(b) - int'(a);
    return clamp8(int'(a) + ((d * int'(w)) >>> 8));
  endfunction

  // chroma is scaled and rotated first, so one matrix serves all 16 sets
  function automatic logic [23:0] csc(input logic [7:0] y, input logic [7:0] cb,
                                      input logic [7:0] cr, input logic [3:0] sel,
                                      input logic [31:0] br);
    int d, us, vs, uh, vh, r, g, b;
    d  = int'(y) - Y_OFS;
    us = ((int'(cb) - C_OFS) * SAT_TAB[sel[1:0]]) >>> 8;
    vs = ((int'(cr) - C_OFS) * SAT_TAB[sel[1:0]]) >>> 8;
    uh = us + ((vs * HUE_TAB[sel[3:2]]) >>> 8);
    vh = vs - ((us * HUE_TAB[sel[3:2]]) >>> 8);
    r  = ((K_Y * d + K_RV * vh + ROUND) >>> 8) + int'($signed(br[7:0]));
    g  = ((K_Y * d - K_GU * uh - K_GV * vh + ROUND) >>> 8) + int'($signed(br[15:8]));
    b  = ((K_Y * d + K_BU * uh + ROUND) >>> 8) + int'($signed(br[23:16]));
    return {clamp8(r), clamp8(g), clamp8(b)};
  endfunction

  // ==========================================================================
  // combinational datapath
  logic [IDX_W-1:0] idx;
  logic [15:0]      prev_pix;
  logic [7:0]       yv, cv, yt, smooth, filt;
  logic [23:0]      vid_pix;
  logic [16:0]      hsum, vsum;
  logic             gfx_take, vid_take, adv, c_take, exhaust, hload;
  logic             line_init, row_start, in_win, vid_avail, owed, use_vid;

  // front end: vertical blend, averaging with the previous fetched line, 3-tap luma filter
  always_comb begin
    idx      = src_cnt_reg[IDX_W-1:0];
    prev_pix = (src_line_reg == 12'h000) ? src_data : lb_mem[idx];     // top line has no prior
    yv       = lerp8(prev_pix[7:0], src_data[7:0], vfrac_reg);
    cv       = lerp8(prev_pix[15:8], src_data[15:8], vfrac_reg);
    yt       = yv;
    if (ctrl_reg[CTRL_TAVG_BIT] && ctrl_reg[CTRL_ILACE_BIT]) begin
      yt = 8'((({1'b0, yv} + {1'b0, fld_mem[idx]}) >> 1));
    end
    smooth = 8'(({2'b00, y2_reg} + {1'b0, y1_reg, 1'b0} + {2'b00, yt} + 10'h002) >> 2);
    filt   = smooth;
    if (ctrl_reg[CTRL_EDGE_BIT]) begin
      filt = clamp8(2 * int'(y1_reg) - int'(smooth));
    end
  end

  // horizontal 2-tap triangle between held neighbours
  always_comb begin
    vid_pix = {lerp8(hp0_reg[23:16], hp1_reg[23:16], hfrac_reg),
               lerp8(hp0_reg[15:8], hp1_reg[15:8], hfrac_reg),
               lerp8(hp0_reg[7:0], hp1_reg[7:0], hfrac_reg)};
  end

  // handshake terms shared by the processes below
  assign gfx_take  = gfx_valid & gfx_ready_reg;
  assign adv       = src_valid & src_ready_reg;
  assign line_init = (st_reg == ST_IDLE) & line_pend_reg;
  assign in_win    = (gfx_x >= win_x_reg) && ({1'b0, gfx_x} < {1'b0, win_x_reg} + {1'b0, win_w_reg})
                   && (gfx_y >= win_y_reg)
                   && ({1'b0, gfx_y} < {1'b0, win_y_reg} + {1'b0, win_h_reg});
  assign row_start = gfx_take & (gfx_x == 12'h000) & ctrl_reg[CTRL_OVL_BIT]
                   && (gfx_y >= win_y_reg)
                   && ({1'b0, gfx_y} < {1'b0, win_y_reg} + {1'b0, win_h_reg});
  assign vid_avail = (st_reg == ST_RUN) & (h_need_reg == 10'h000) & (out_cnt_reg < win_w_reg);
  assign owed      = ctrl_reg[CTRL_OVL_BIT] & (line_pend_reg | (st_reg == ST_FETCH) |
                     ((st_reg == ST_RUN) & (out_cnt_reg < win_w_reg)));
  assign use_vid   = ctrl_reg[CTRL_OVL_BIT] & in_win & vid_avail;
  assign vid_take  = gfx_take & use_vid;
  assign c_take    = c_valid_reg & ((st_reg == ST_DRAIN) | (h_need_reg != 10'h000));
  // source ran short: replicate the last pixel rather than hang the raster
  assign exhaust   = !c_valid_reg & (h_need_reg != 10'h000) & (st_reg == ST_RUN)
                   & (src_cnt_reg == src_w_reg) & !src_ready_reg;
  assign hload     = (c_take & (st_reg == ST_RUN)) | exhaust;
  assign hsum      = {9'h000, hfrac_reg} + {1'b0, hstep_reg};
  assign vsum      = {9'h000, vfrac_reg} + {1'b0, vstep_reg};

  // ==========================================================================
  // register write port
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg      <= CTRL_RST;
      key_reg       <= '0;
      win_x_reg     <= '0;
      win_y_reg     <= '0;
      win_w_reg     <= WIN_W_RST;
      win_h_reg     <= WIN_H_RST;
      start_reg     <= '0;
      pitch_reg     <= PITCH_RST;
      src_w_reg     <= SRC_W_RST;
      hstep_reg     <= STEP_RST;
      vstep_reg     <= STEP_RST;
      bright_reg    <= '0;
      field_off_reg <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        OFF_CTRL:      ctrl_reg <= reg_wdata;
        OFF_KEY:       key_reg <= {8'h00, reg_wdata[23:0]};
        OFF_WIN_POS: begin
          win_x_reg <= reg_wdata[11:0];
          win_y_reg <= reg_wdata[27:16];
        end
        OFF_WIN_SIZE: begin
          win_w_reg <= reg_wdata[11:0];
          win_h_reg <= reg_wdata[27:16];
        end
        OFF_START:     start_reg <= reg_wdata;
        OFF_PITCH:     pitch_reg <= reg_wdata[15:0];
        OFF_SRC_W:     src_w_reg <= reg_wdata[11:0];
        OFF_STEP: begin
          hstep_reg <= reg_wdata[15:0];
          vstep_reg <= reg_wdata[31:16];
        end
        OFF_BRIGHT:    bright_reg <= {8'h00, reg_wdata[23:0]};
        OFF_FIELD_OFF: field_off_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  // read port: data valid only in the cycle after the strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        OFF_CTRL:      rdata_reg <= ctrl_reg;
        OFF_KEY:       rdata_reg <= key_reg;
        OFF_WIN_POS:   rdata_reg <= {4'h0, win_y_reg, 4'h0, win_x_reg};
        OFF_WIN_SIZE:  rdata_reg <= {4'h0, win_h_reg, 4'h0, win_w_reg};
        OFF_START:     rdata_reg <= start_reg;
        OFF_PITCH:     rdata_reg <= {16'h0000, pitch_reg};
        OFF_SRC_W:     rdata_reg <= {20'h00000, src_w_reg};
        OFF_STEP:      rdata_reg <= {vstep_reg, hstep_reg};
        OFF_BRIGHT:    rdata_reg <= bright_reg;
        OFF_FIELD_OFF: rdata_reg <= field_off_reg;
        OFF_STATUS:    rdata_reg <= {4'h0, src_line_reg, 14'h0000,
                                     (st_reg != ST_IDLE), field_reg};
        default:       rdata_reg <= '0;
      endcase
    end else begin
      rdata_reg <= '0;
    end
  end

  // ==========================================================================
  // line sequencer, vertical phase and field tracking
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg          <= ST_IDLE;
      line_pend_reg   <= 1'b0;
      field_reg       <= 1'b0;
      vfrac_reg       <= '0;
      src_line_reg    <= '0;
      v_store_reg     <= 1'b0;
      fetch_valid_reg <= 1'b0;
      fetch_addr_reg  <= '0;
    end else if (gfx_take && gfx_sof) begin
      // new display frame shows the next field of an interlaced source
      field_reg       <= ctrl_reg[CTRL_ILACE_BIT] & ~field_reg;
      vfrac_reg       <= (ctrl_reg[CTRL_ILACE_BIT] & ~field_reg) ? PHASE_HALF : 8'h00;
      src_line_reg    <= '0;
      st_reg          <= ST_IDLE;
      fetch_valid_reg <= 1'b0;
      line_pend_reg   <= row_start;
    end else begin
      if (row_start) begin
        line_pend_reg <= 1'b1;
      end else if (line_init) begin
        line_pend_reg <= 1'b0;
      end
      case (st_reg)
        ST_IDLE: begin
          if (line_pend_reg) begin
            // double buffer: the second field lives at its own offset
            fetch_addr_reg  <= start_reg + (field_reg ? field_off_reg : 32'h0000_0000)
                             + 32'(src_line_reg) * 32'(pitch_reg);
            fetch_valid_reg <= 1'b1;
            v_store_reg     <= vsum[16:8] != 9'h000;
            st_reg          <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (fetch_ready) begin
            fetch_valid_reg <= 1'b0;
            st_reg          <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (out_cnt_reg == win_w_reg) begin
            st_reg <= ST_DRAIN;
          end
        end
        ST_DRAIN: begin
          if (src_cnt_reg == src_w_reg && !c_valid_reg) begin
            src_line_reg <= src_line_reg + {3'h0, vsum[16:8]};
            vfrac_reg    <= vsum[7:0];
            st_reg       <= ST_IDLE;
          end
        end
        default: st_reg <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // source intake: vertical blend, filter, colour conversion
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      src_cnt_reg   <= '0;
      src_ready_reg <= 1'b0;
      c_valid_reg   <= 1'b0;
      y1_reg        <= '0;
      y2_reg        <= '0;
      cb_reg        <= 8'h80;
      cr_reg        <= 8'h80;
      c_rgb_reg     <= '0;
    end else if (line_init) begin
      src_cnt_reg   <= '0;
      src_ready_reg <= 1'b0;
      c_valid_reg   <= 1'b0;
    end else begin
      // ready drops for a cycle after each take, trading rate for a flopped ready
      src_ready_reg <= !adv && ((st_reg == ST_RUN) || (st_reg == ST_DRAIN))
                    && (src_cnt_reg < src_w_reg) && (!c_valid_reg || c_take);
      if (adv) begin
        src_cnt_reg <= src_cnt_reg + 12'h001;
        y2_reg      <= y1_reg;
        y1_reg      <= yt;
        if (src_cnt_reg[0]) begin
          cr_reg <= cv;
        end else begin
          cb_reg <= cv;
        end
        // stage order is fixed: blend, filter, convert, then stretch
        c_rgb_reg   <= csc(filt, cb_reg, cr_reg, ctrl_reg[CTRL_CSC_LSB +: 4],
                           bright_reg);
        c_valid_reg <= src_cnt_reg != 12'h000;
      end else if (c_take) begin
        c_valid_reg <= 1'b0;
      end
    end
  end

  // line stores have no reset; the top line of a frame never reads lb_mem, but averaging reads fld_mem there
  always_ff @(posedge clk) begin
    if (adv && v_store_reg) begin
      lb_mem[idx] <= src_data;
    end
    if (adv) begin
      fld_mem[idx] <= yv;
    end
  end

  // ==========================================================================
  // horizontal stretch: phase steps per output pixel, pulls on carry
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hp0_reg     <= '0;
      hp1_reg     <= '0;
      hfrac_reg   <= '0;
      h_need_reg  <= PRIME_CNT;
      out_cnt_reg <= '0;
    end else if (line_init) begin
      hfrac_reg   <= '0;
      h_need_reg  <= PRIME_CNT;
      out_cnt_reg <= '0;
    end else if (vid_take) begin
      hfrac_reg   <= hsum[7:0];
      h_need_reg  <= h_need_reg + {1'b0, hsum[16:8]};
      out_cnt_reg <= out_cnt_reg + 12'h001;
    end else if (hload) begin
      hp0_reg    <= hp1_reg;
      hp1_reg    <= exhaust ? hp1_reg : c_rgb_reg;
      h_need_reg <= h_need_reg - 10'h001;
    end
  end

  // ==========================================================================
  // composition and display output
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gfx_ready_reg <= 1'b0;
      out_valid_reg <= 1'b0;
      out_pixel_reg <= '0;
    end else begin
      // ready only when the output slot is sure to be free and owed video is ready
      gfx_ready_reg <= !gfx_take && (!out_valid_reg || out_ready)
                    && (!owed || vid_avail);
      if (gfx_take) begin
        out_valid_reg <= 1'b1;
        if (ctrl_reg[CTRL_KEY_BIT]) begin
          out_pixel_reg <= (use_vid && gfx_pixel == key_reg[23:0]) ? vid_pix
                                                                   : gfx_pixel;
        end else begin
          out_pixel_reg <= use_vid ? vid_pix : gfx_pixel;
        end
      end else if (out_ready) begin
        out_valid_reg <= 1'b0;
      end
    end
  end

  assign reg_rdata   = rdata_reg;
  assign fetch_valid = fetch_valid_reg;
  assign fetch_addr  = fetch_addr_reg;
  assign fetch_len   = src_w_reg;
  assign src_ready   = src_ready_reg;
  assign gfx_ready   = gfx_ready_reg;
  assign out_valid   = out_valid_reg;
  assign out_pixel   = out_pixel_reg;

endmodule

// ### verification/video_overlay_scaler_assertions.sv
`timescale 1ns/1ns
module scaler_checker
  import scaler_pkg::*;
(
  input wire logic        clk,         // clock
  input wire logic        rstn,        // reset, low
  input wire logic [7:0]  reg_addr,    // address
  input wire logic [31:0] reg_wdata,   // write data
  input wire logic        reg_wr,      // write
  input wire logic        fetch_valid, // fetch req
  input wire logic        fetch_ready, // fetch ack
  input wire logic [31:0] fetch_addr,  // fetch addr
  input wire logic [11:0] fetch_len,   // fetch len
  input wire logic        gfx_valid,   // gfx valid
  input wire logic        gfx_ready,   // gfx ready
  input wire logic [23:0] gfx_pixel,   // gfx rgb
  input wire logic        out_valid,   // out valid
  input wire logic        out_ready,   // out ready
  input wire logic [23:0] out_pixel    // out rgb
);
  // ====
  // shadow of the settings that decide composition and fetch length
  logic [1:0]  mode_reg;
  logic [23:0] key_reg;
  logic [11:0] srcw_reg;
  wire         take = gfx_valid && gfx_ready;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_reg <= 2'h0;
      key_reg  <= 24'h000000;
      srcw_reg <= SRC_W_RST;
    end else if (reg_wr) begin
      if (reg_addr == OFF_CTRL) mode_reg <= reg_wdata[1:0];
      if (reg_addr == OFF_KEY) key_reg <= reg_wdata[23:0];
      if (reg_addr == OFF_SRC_W) srcw_reg <= reg_wdata[11:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_fetch_hold:
    assert property (fetch_valid && !fetch_ready |=> fetch_valid && $stable(fetch_addr))
    else $error("fetch request changed before taken");
  a_fetch_once:
    assert property (fetch_valid && fetch_ready |=> !fetch_valid)
    else $error("fetch request repeated");
  a_fetch_len:
    assert property (fetch_valid |-> fetch_len == srcw_reg)
    else $error("fetch length differs from source width");
  a_out_hold:
    assert property (out_valid && !out_ready |=> out_valid && $stable(out_pixel))
    else $error("output dropped while stalled");
  a_gfx_gap:
    assert property (take |=> !gfx_ready)
    else $error("graphics ready straight after a take");
  a_out_follows:
    assert property (take |=> out_valid)
    else $error("no output after graphics take");
  a_gfx_pass:
    assert property (take && !mode_reg[0] |=> out_pixel == $past(gfx_pixel))
    else $error("overlay off but output not graphics");
  a_key_miss:
    assert property (take && (&mode_reg) && gfx_pixel != key_reg |=> out_pixel == $past(gfx_pixel))
    else $error("key mismatch but output not graphics");
endmodule
bind video_overlay_scaler scaler_checker chk (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
  .fetch_valid, .fetch_ready, .fetch_addr, .fetch_len, .gfx_valid, .gfx_ready, .gfx_pixel,
  .out_valid, .out_ready, .out_pixel);

// ### verification/frame_source_model.sv
`timescale 1ns/1ns
module frame_source_model (
  input  wire logic        clk,         // clock
  input  wire logic        rstn,        // reset, low
  input  wire logic        slow,        // stall often
  input  wire logic        fetch_valid, // line request
  input  wire logic [11:0] fetch_len,   // pixels owed
  output logic             fetch_ready, // request taken
  output logic             src_valid,   // pixel offered
  input  wire logic        src_ready,   // pixel taken
  output logic      [15:0] src_data     // chroma, luma
);
  logic [11:0] left_reg;
  logic [2:0]  tick_reg;
  // ====
  // one line at a time; idle data is inverted so stale words never look valid
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fetch_ready <= 1'b0;
      src_valid   <= 1'b0;
      src_data    <= 16'h0000;
      left_reg    <= 12'h000;
      tick_reg    <= 3'h0;
    end else begin
      tick_reg    <= tick_reg + 3'h1;
      fetch_ready <= fetch_valid && !fetch_ready && left_reg == 12'h000 && !(slow && tick_reg[1]);
      if (fetch_valid && fetch_ready) left_reg <= fetch_len;
      if (src_valid && src_ready) begin
        left_reg  <= left_reg - 12'h001;
        src_valid <= 1'b0;
        src_data  <= ~src_data;
      end else if (left_reg != 12'h000 && !src_valid && !(slow && tick_reg[0])) begin
        src_valid <= 1'b1;
        src_data  <= {tick_reg, 5'h10, left_reg[7:0]};
      end
    end
  end
endmodule

// ### verification/test_video_overlay_scaler.sv
`timescale 1ns/1ns
module test_video_overlay_scaler
  import scaler_pkg::*;
;
  localparam logic [11:0] WX = 12'h004, WY = 12'h001, WW = 12'h008, WH = 12'h003;
  logic        clk = 1'b0, rstn = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0;
  logic        gfx_valid = 1'b0, gfx_sof = 1'b0, out_ready = 1'b0, ovl = 0, key_on = 0;
  logic        fetch_ready, src_valid, src_ready, fetch_valid, gfx_ready, out_valid, armed;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, fetch_addr, first_addr, prev_addr;
  logic [11:0] gfx_x = 12'h000, gfx_y = 12'h000, fetch_len;
  logic [23:0] gfx_pixel = 24'h0, out_pixel, key = 24'h5A5A5A;
  logic [15:0] src_data;
  logic [24:0] exp_q[$], e;
  integer      seed = 32'h2C1F, bad_count = 0, checks_done = 0, i, n;
  always #4 clk = ~clk;
  video_overlay_scaler #(.MAX_W(64)) dut (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .fetch_valid, .fetch_ready, .fetch_addr, .fetch_len, .src_valid, .src_ready,
    .src_data, .gfx_valid, .gfx_ready, .gfx_sof, .gfx_x, .gfx_y, .gfx_pixel, .out_valid,
    .out_ready, .out_pixel);
  frame_source_model mem (.clk, .rstn, .slow, .fetch_valid, .fetch_len, .fetch_ready,
    .src_valid, .src_ready, .src_data);
  // ====
  // bus, check and verdict tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(posedge clk);
    check(reg_rdata, exp, "register");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // graphics must show wherever video has no claim
  function automatic logic want_gfx(input logic [11:0] x, y, input logic [23:0] p);
    return !ovl || x < WX || x >= WX + WW || y < WY || y >= WY + WH || (key_on && p != key);
  endfunction
  // one raster of 24 x 6, then wait for the display to drain
  task automatic frame();
    for (int y = 0; y < 6; y++)
      for (int x = 0; x < 24; x++) begin
        gfx_valid <= 1'b1;
        gfx_sof   <= (x == 0 && y == 0);
        gfx_x     <= 12'(x);
        gfx_y     <= 12'(y);
        gfx_pixel <= (key_on && seed[0]) ? key : 24'($random(seed));
        n = 0;
        do begin
          @(posedge clk);
          n++;
        end while (gfx_ready !== 1'b1 && n < 4000);
        if (gfx_ready !== 1'b1) bad_count++;
      end
    gfx_valid <= 1'b0;
    @(posedge clk);
    for (n = 0; exp_q.size() != 0 && n < 4000; n++) @(posedge clk);
    if (exp_q.size() != 0) bad_count++;
  endtask
  // scoreboard and first fetch of each frame; display stalls at random
  always @(posedge clk) begin
    out_ready <= ($random(seed) & 3) != 0;
    if (gfx_valid && gfx_ready) exp_q.push_back({want_gfx(gfx_x, gfx_y, gfx_pixel), gfx_pixel});
    if (out_valid && out_ready) begin
      check({31'h0, exp_q.size() == 0}, 32'h0, "extra");
      e = exp_q.pop_front();
      if (e[24]) check({8'h00, out_pixel}, {8'h00, e[23:0]}, "pixel");
    end
    if (gfx_valid && gfx_ready && gfx_sof) armed <= 1'b1;
    if (fetch_valid && fetch_ready && armed) begin
      first_addr <= fetch_addr;
      armed      <= 1'b0;
    end
  end
  initial begin
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(OFF_CTRL, CTRL_RST);
    rd(OFF_STEP, {STEP_RST, STEP_RST});
    rd(OFF_WIN_SIZE, {4'h0, WIN_H_RST, 4'h0, WIN_W_RST});
    rd(OFF_SRC_W, {20'h0, SRC_W_RST});
    rd(OFF_PITCH, {16'h0, PITCH_RST});
    rd(8'h30, 32'h0);
    wr(OFF_STEP, 32'h0100_00C0);
    rd(OFF_STEP, 32'h0100_00C0);
    wr(OFF_WIN_POS, {4'h0, WY, 4'h0, WX});
    wr(OFF_WIN_SIZE, {4'h0, WH, 4'h0, WW});
    wr(OFF_START, 32'h0000_1000);
    wr(OFF_PITCH, 32'h0000_0040);
    wr(OFF_SRC_W, 32'h0000_0008);
    wr(OFF_FIELD_OFF, 32'h0000_0800);
    wr(OFF_KEY, {8'h00, key});
    frame();
    ovl = 1;
    for (i = 0; i < 16; i++) begin
      wr(OFF_CTRL, 32'h1 | (i << CTRL_CSC_LSB) | ((i & 1) << CTRL_EDGE_BIT));
      wr(OFF_BRIGHT, $random(seed));
      frame();
      check(first_addr, 32'h0000_1000, "start");
    end
    key_on = 1;
    slow <= 1'b1;
    wr(OFF_CTRL, 32'h0000_0003);
    frame();
    frame();
    key_on = 0;
    wr(OFF_CTRL, 32'h0000_0019);
    frame();
    prev_addr = first_addr;
    rd(OFF_STATUS, 32'h0003_0001);
    frame();
    check(first_addr + prev_addr, 32'h0000_2800, "fields");
    tally_and_finish();
  end
  // hang guard, well past the expected run length
  initial begin
    #(90000 * 8);
    bad_count++;
    tally_and_finish();
  end
endmodule
